/* design/slc_consts.svh */
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH
`define SLC_IDX_RSVD_A 8'h10
`define SLC_IDX_RSVD_B 8'h11
`define SLC_IDX_DEBUG 8'h1F
`define SLC_IDX_EXT_STAT 8'h20
`define SLC_IDX_CORE_STAT 8'h40
`define SLC_IDX_EXT_SETUP 8'h80
`define SLC_IDX_FWD 8'hA0
`define SLC_IDX_ROUTE_ID 8'hC0
`define SLC_IDX_ROUTE_DIR 8'hC1
`define SLC_N_EXT_STAT 9
`define SLC_N_EXT_SETUP 9
`define SLC_N_LINK 8
`define SLC_B_ENABLE 31
`define SLC_B_FIVE_WIRE 30
`define SLC_B_ERROR 27
`define SLC_B_CRED_ISSUED 26
`define SLC_B_CRED_HELD 25
`define SLC_B_CRED_REQ 24
`define SLC_B_RX_RESET 23
`define SLC_B_FWD_EN 31
`define SLC_B_FWD_CORE 8
`define SLC_DIR_MASK 32'h00000F00
`define SLC_NET_MASK 32'h00000030
`define SLC_SPACING_MASK 32'hC03FFFFF
`define SLC_FWD_MASK 32'h8000011F
`define SLC_RSVD_MASK 32'h00000003
`define SLC_DEBUG_MASK 32'h00000013
`endif

/* design/slc_pkg.sv */
package slc_pkg;
    typedef enum logic [1:0] {
        SLC_TGT_SWITCH,
        SLC_TGT_CORE,
        SLC_TGT_CONTROL,
        SLC_TGT_UNDEF
    } slc_target_t;
    typedef enum {
        SLC_TX_IDLE,
        SLC_TX_SYMBOL,
        SLC_TX_SYM_GAP,
        SLC_TX_TOK_GAP
    } slc_tx_state_t;
endpackage

/* design/slc_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "slc_consts.svh"
// Behaviour
// RULE_01: Debug origin bits name halting core.
// RULE_02: Status shows two-bit source target type.
// RULE_03: Status shows destination link while busy.
// RULE_04: External status holds writable routing direction.
// RULE_05: Each link holds writable network number.
// RULE_06: Junk bit shows discarded current packet.
// RULE_07: Bits show destination and source occupancy.
// RULE_08: Eight core links lack direction field.
// RULE_09: One setup register per external link.
// RULE_10: Top setup bit enables link, steers pins.
// RULE_11: Wire-mode bit selects two or five wires.
// RULE_12: Error bit shows overflow or bad token.
// RULE_13: Credit issued and held bits, reset zero.
// RULE_14: Credit write clears credit, sends request.
// RULE_15: Receiver reset restarts token symbol framing.
// RULE_16: Symbol gap at least value plus one.
// RULE_17: Token gap at least value plus one.
// RULE_18: Static forwarding bypasses routing entirely.
// RULE_19: Forward target core and channel end fields.
// RULE_20: Static registers map links C,D,A,B,G,H,E,F.
// RULE_21: Route by highest mismatching identifier bit.
// RULE_22: Reserved and read-only writes ignored, read zero; code keeps reserved bits 1:0 at 0x10/0x11.
module slc_regs
    import slc_pkg::*;
#(
    parameter int N_EXT = 9,
    parameter int N_CORE = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Debug event source
    input wire logic global_halt_event,
    input wire logic halt_by_core_zero,
    input wire logic halt_by_core_one,
    // Per-link switch status, external then core-side
    input wire logic [2*N_EXT-1:0] ext_target_type,
    input wire logic [8*N_EXT-1:0] ext_dest_link,
    input wire logic [N_EXT-1:0] ext_junk,
    input wire logic [N_EXT-1:0] ext_dest_busy,
    input wire logic [N_EXT-1:0] ext_src_busy,
    input wire logic [2*N_CORE-1:0] core_target_type,
    input wire logic [8*N_CORE-1:0] core_dest_link,
    input wire logic [N_CORE-1:0] core_junk,
    input wire logic [N_CORE-1:0] core_dest_busy,
    input wire logic [N_CORE-1:0] core_src_busy,
    // External link receive and credit events
    input wire logic [N_EXT-1:0] rx_error,
    input wire logic [N_EXT-1:0] credit_issued_set,
    input wire logic [N_EXT-1:0] credit_grant,
    // External link control, then core-side network numbers
    output logic [N_EXT-1:0] link_enable,
    output logic [N_EXT-1:0] link_five_wire,
    output logic [N_EXT-1:0] credit_request_token,
    output logic [N_EXT-1:0] rx_restart,
    output logic [4*N_EXT-1:0] link_direction,
    output logic [2*N_EXT-1:0] ext_network,
    output logic [2*N_CORE-1:0] core_network,
    // Transmit pacing per external link
    input wire logic [N_EXT-1:0] tx_symbol_req,
    input wire logic [N_EXT-1:0] tx_token_last,
    output logic [N_EXT-1:0] tx_symbol_go,
    // Static forwarding, index 0..7 in register order
    output logic [`SLC_N_LINK-1:0] fwd_enable,
    output logic [`SLC_N_LINK-1:0] fwd_core,
    output logic [5*`SLC_N_LINK-1:0] fwd_chanend,
    // Routing lookup
    input wire logic [15:0] route_dest_id,
    output logic [3:0] route_dir
);
    logic [31:0] debug_reg;
    logic [31:0] rsvd_a_reg, rsvd_b_reg;
    logic [31:0] ext_stat_reg [N_EXT];
    logic [31:0] core_stat_reg [N_CORE];
    logic [31:0] setup_reg [N_EXT];
    logic [31:0] fwd_reg [`SLC_N_LINK];
    logic [15:0] node_id_reg;
    logic [63:0] route_tab_reg;
    logic [N_EXT-1:0] err_reg, cred_iss_reg, cred_held_reg;
    logic aw_held_reg, w_held_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic wr_do;
    logic [7:0] wr_idx, rd_idx;
    logic [31:0] wmask;
    logic [31:0] rd_next;
    logic rd_hit, wr_hit;

    function automatic logic idx_mapped(input logic [7:0] idx);
        return idx == `SLC_IDX_RSVD_A || idx == `SLC_IDX_RSVD_B || idx == `SLC_IDX_DEBUG ||
               idx == `SLC_IDX_ROUTE_ID || idx == `SLC_IDX_ROUTE_DIR ||
               (idx >= `SLC_IDX_EXT_STAT && idx < `SLC_IDX_EXT_STAT + 8'(N_EXT)) ||
               (idx >= `SLC_IDX_CORE_STAT && idx < `SLC_IDX_CORE_STAT + 8'(N_CORE)) ||
               (idx >= `SLC_IDX_EXT_SETUP && idx < `SLC_IDX_EXT_SETUP + 8'(N_EXT)) ||
               (idx >= `SLC_IDX_FWD && idx < `SLC_IDX_FWD + 8'(`SLC_N_LINK));
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] m);
        return (old & ~(wmask & m)) | (wdata_reg & wmask & m);
    endfunction

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_idx = awaddr_reg[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    // Address and data are latched independently so either may arrive first.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_do) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    assign wr_hit = idx_mapped(wr_idx) && awaddr_reg[11:10] == 2'b00;
    assign rd_hit = idx_mapped(rd_idx) && s_axi_araddr[11:10] == 2'b00;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
        end else if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rsvd_a_reg <= 32'h00000000;
            rsvd_b_reg <= 32'h00000000;
            node_id_reg <= 16'h0000;
            route_tab_reg <= 64'h0000000000000000;
        end else if (wr_do) begin
            if (wr_idx == `SLC_IDX_RSVD_A) begin
                rsvd_a_reg <= wmerge(rsvd_a_reg, `SLC_RSVD_MASK); // RULE_22
            end
            if (wr_idx == `SLC_IDX_RSVD_B) begin
                rsvd_b_reg <= wmerge(rsvd_b_reg, `SLC_RSVD_MASK); // RULE_22
            end
            if (wr_idx == `SLC_IDX_ROUTE_ID) begin
                node_id_reg <= wdata_reg[15:0];
            end
            if (wr_idx == `SLC_IDX_ROUTE_DIR) begin
                route_tab_reg <= {route_tab_reg[31:0], wdata_reg};
            end
        end
    end

    // A hardware event in the same cycle as a software write wins.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            debug_reg <= 32'h00000000;
        end else if (global_halt_event) begin
            debug_reg <= {debug_reg[31:2], halt_by_core_one, halt_by_core_zero}; // RULE_01
        end else if (wr_do && wr_idx == `SLC_IDX_DEBUG) begin
            debug_reg <= wmerge(debug_reg, `SLC_DEBUG_MASK); // RULE_22
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_EXT; g++) begin : g_ext
            logic [31:0] sw_reg;
            logic [10:0] gap_cnt_reg;
            slc_tx_state_t tx_state;
            logic wr_stat, wr_setup;
            assign wr_stat = wr_do && wr_idx == `SLC_IDX_EXT_STAT + 8'(g);
            assign wr_setup = wr_do && wr_idx == `SLC_IDX_EXT_SETUP + 8'(g);
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sw_reg <= 32'h00000000;
                end else if (wr_stat) begin
                    sw_reg <= wmerge(sw_reg, `SLC_DIR_MASK | `SLC_NET_MASK); // RULE_04
                end
            end
            always_comb begin
                ext_stat_reg[g] = {6'h00, ext_target_type[2*g +: 2], ext_dest_link[8*g +: 8], // RULE_02
                                   4'h0, sw_reg[11:8], 2'b00, sw_reg[5:4], 1'b0, // RULE_05
                                   ext_junk[g], ext_dest_busy[g], ext_src_busy[g]}; // RULE_07
                if (!ext_src_busy[g] && !ext_dest_busy[g]) begin
                    ext_stat_reg[g][23:16] = 8'h00; // RULE_03
                end
            end
            assign link_direction[4*g +: 4] = sw_reg[11:8];
            assign ext_network[2*g +: 2] = sw_reg[5:4];
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    setup_reg[g] <= 32'h00000000;
                end else if (wr_setup) begin
                    setup_reg[g] <= wmerge(setup_reg[g], `SLC_SPACING_MASK); // RULE_09
                end
            end
            assign link_enable[g] = setup_reg[g][`SLC_B_ENABLE]; // RULE_10
            assign link_five_wire[g] = setup_reg[g][`SLC_B_FIVE_WIRE]; // RULE_11
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    credit_request_token[g] <= 1'b0;
                    rx_restart[g] <= 1'b0;
                end else begin
                    credit_request_token[g] <= wr_setup && wmask[`SLC_B_CRED_REQ] &&
                                               wdata_reg[`SLC_B_CRED_REQ]; // RULE_14
                    rx_restart[g] <= wr_setup && wmask[`SLC_B_RX_RESET]; // RULE_15
                end
            end
            // Events beat clears; the error and credit-issued stickies are cleared by receiver reset.
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    err_reg[g] <= 1'b0;
                    cred_iss_reg[g] <= 1'b0;
                    cred_held_reg[g] <= 1'b0;
                end else begin
                    if (rx_error[g]) begin
                        err_reg[g] <= 1'b1; // RULE_12
                    end else if (rx_restart[g]) begin
                        err_reg[g] <= 1'b0;
                    end
                    if (credit_issued_set[g]) begin
                        cred_iss_reg[g] <= 1'b1; // RULE_13
                    end else if (rx_restart[g]) begin
                        cred_iss_reg[g] <= 1'b0;
                    end
                    if (credit_grant[g]) begin
                        cred_held_reg[g] <= 1'b1; // RULE_13
                    end else if (credit_request_token[g]) begin
                        cred_held_reg[g] <= 1'b0; // RULE_14
                    end
                end
            end
            assign tx_symbol_go[g] = (tx_state == SLC_TX_IDLE) && tx_symbol_req[g];
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    tx_state <= SLC_TX_IDLE;
                    gap_cnt_reg <= 11'h000;
                end else begin
                    case (tx_state)
                        SLC_TX_IDLE: begin
                            if (tx_symbol_go[g]) begin
                                tx_state <= tx_token_last[g] ? SLC_TX_TOK_GAP : SLC_TX_SYM_GAP;
                                gap_cnt_reg <= tx_token_last[g] ? setup_reg[g][10:0] : // RULE_17
                                                                  setup_reg[g][21:11]; // RULE_16
                            end
                        end
                        SLC_TX_SYM_GAP, SLC_TX_TOK_GAP: begin
                            if (gap_cnt_reg == 11'h000) begin
                                tx_state <= SLC_TX_IDLE;
                            end else begin
                                gap_cnt_reg <= gap_cnt_reg - 11'h001;
                            end
                        end
                        default: begin
                            tx_state <= SLC_TX_IDLE;
                        end
                    endcase
                end
            end
        end
        for (g = 0; g < N_CORE; g++) begin : g_core
            logic [1:0] net_reg;
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    net_reg <= 2'b00;
                end else if (wr_do && wmask[4] && wr_idx == `SLC_IDX_CORE_STAT + 8'(g)) begin
                    net_reg <= wdata_reg[5:4]; // RULE_05
                end
            end
            always_comb begin
                core_stat_reg[g] = {6'h00, core_target_type[2*g +: 2], core_dest_link[8*g +: 8],
                                    10'h000, net_reg, 1'b0, core_junk[g], // RULE_08
                                    core_dest_busy[g], core_src_busy[g]}; // RULE_07
                if (!core_src_busy[g] && !core_dest_busy[g]) begin
                    core_stat_reg[g][23:16] = 8'h00; // RULE_03
                end
            end
            assign core_network[2*g +: 2] = net_reg;
        end
        for (g = 0; g < `SLC_N_LINK; g++) begin : g_fwd
            // Index order is C, D, A, B, G, H, E, F; link naming lives outside.
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    fwd_reg[g] <= 32'h00000000;
                end else if (wr_do && wr_idx == `SLC_IDX_FWD + 8'(g)) begin
                    fwd_reg[g] <= wmerge(fwd_reg[g], `SLC_FWD_MASK); // RULE_20
                end
            end
            assign fwd_enable[g] = fwd_reg[g][`SLC_B_FWD_EN]; // RULE_18
            assign fwd_core[g] = fwd_reg[g][`SLC_B_FWD_CORE]; // RULE_19
            assign fwd_chanend[5*g +: 5] = fwd_reg[g][4:0]; // RULE_19
        end
    endgenerate

    always_comb begin
        logic [15:0] diff;
        diff = route_dest_id ^ node_id_reg;
        route_dir = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (diff[i]) begin
                route_dir = route_tab_reg[4*i +: 4]; // RULE_21
            end
        end
    end

    always_comb begin
        case (rd_idx)
            `SLC_IDX_RSVD_A: rd_next = rsvd_a_reg;
            `SLC_IDX_RSVD_B: rd_next = rsvd_b_reg;
            `SLC_IDX_DEBUG: rd_next = debug_reg;
            `SLC_IDX_ROUTE_ID: rd_next = {16'h0000, node_id_reg};
            `SLC_IDX_ROUTE_DIR: rd_next = route_tab_reg[31:0];
            default: rd_next = 32'h00000000;
        endcase
        for (int i = 0; i < N_EXT; i++) begin
            if (rd_idx == `SLC_IDX_EXT_STAT + 8'(i)) begin
                rd_next = ext_stat_reg[i];
            end
            if (rd_idx == `SLC_IDX_EXT_SETUP + 8'(i)) begin
                rd_next = setup_reg[i];
                rd_next[`SLC_B_ERROR] = err_reg[i];
                rd_next[`SLC_B_CRED_ISSUED] = cred_iss_reg[i];
                rd_next[`SLC_B_CRED_HELD] = cred_held_reg[i];
            end
        end
        for (int i = 0; i < N_CORE; i++) begin
            if (rd_idx == `SLC_IDX_CORE_STAT + 8'(i)) begin
                rd_next = core_stat_reg[i];
            end
        end
        for (int i = 0; i < `SLC_N_LINK; i++) begin
            if (rd_idx == `SLC_IDX_FWD + 8'(i)) begin
                rd_next = fwd_reg[i];
            end
        end
        if (s_axi_araddr[11:10] != 2'b00) begin
            rd_next = 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_next;
            rresp_reg <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule // slc_regs
`default_nettype wire

/* verif/slc_link_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module slc_link_peer #(
    parameter int N = 9
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bench command
    input wire logic inject_error,
    // Link side of the bank
    input wire logic [N-1:0] link_enable,
    input wire logic [N-1:0] credit_request_token,
    input wire logic [N-1:0] tx_symbol_go,
    output logic [N-1:0] rx_error,
    output logic [N-1:0] credit_issued_set,
    output logic [N-1:0] credit_grant,
    output logic [N-1:0] tx_symbol_req,
    output logic [N-1:0] tx_token_last
);
    logic [N-1:0] credit_request_token_d1;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            credit_request_token_d1 <= '0;
            credit_grant <= '0;
            rx_error <= '0;
        end else begin
            credit_request_token_d1 <= credit_request_token;
            credit_grant <= credit_request_token_d1;
            rx_error <= {{(N-1){1'h0}}, inject_error};
        end
    end
    assign credit_issued_set = credit_grant;
    assign tx_symbol_req = {{(N-1){1'h0}}, link_enable[0]};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) tx_token_last <= '0;
        else if (tx_symbol_go[0]) tx_token_last <= ~tx_token_last;
    end
endmodule // slc_link_peer
`default_nettype wire

/* verif/slc_regs_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module slc_regs_chk #(
    parameter int N_EXT = 9
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Link control
    input wire logic [N_EXT-1:0] credit_request_token,
    input wire logic [N_EXT-1:0] rx_restart,
    input wire logic [N_EXT-1:0] tx_symbol_req,
    input wire logic [N_EXT-1:0] tx_symbol_go
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_r_stall;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid) else $error("read unanswered");
    a_read_hold: assert property (s_r_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_credit_pulse: assert property (|credit_request_token |=> credit_request_token == '0)
        else $error("credit request not a pulse");
    a_restart_pulse: assert property (|rx_restart |=> rx_restart == '0)
        else $error("receiver restart not a pulse");
    a_go_needs_req: assert property ((tx_symbol_go & ~tx_symbol_req) == '0)
        else $error("symbol sent without request");
    a_gap_idle: assert property (tx_symbol_go[0] |=> !tx_symbol_go[0])
        else $error("no idle cycle between symbols");
endmodule // slc_regs_chk
bind slc_regs slc_regs_chk #(.N_EXT(N_EXT)) i_slc_regs_chk (.*);
`default_nettype wire

/* verif/switch_link_config_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module switch_link_config_regs_tb_top;
    typedef struct packed {logic [7:0] i; logic [31:0] w; logic [31:0] r; logic [1:0] s;} slc_row_t;
    logic clk_sys = 1'h0, rst_n = 1'h0, st = 1'h0, inject_error = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic global_halt_event = 1'h0, halt_by_core_zero = 1'h0, halt_by_core_one = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0, route_dir;
    logic [15:0] route_dest_id = '0, core_network;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [8:0] link_enable, link_five_wire, credit_request_token, rx_restart, tx_symbol_go;
    logic [8:0] rx_error, credit_issued_set, credit_grant, tx_symbol_req, tx_token_last;
    logic [35:0] link_direction;
    logic [17:0] ext_network;
    logic [7:0] fwd_enable, fwd_core;
    logic [39:0] fwd_chanend;
    wire logic [17:0] ext_target_type = {16'h0, st, 1'h0};
    wire logic [71:0] ext_dest_link = st ? 72'h5A : 72'h0;
    wire logic [8:0] ext_junk = {8'h0, st}, ext_dest_busy = {8'h0, st}, ext_src_busy = {8'h0, st};
    wire logic [15:0] core_target_type = {15'h0, st};
    wire logic [63:0] core_dest_link = st ? 64'h3 : 64'h0;
    wire logic [7:0] core_junk = {7'h0, st}, core_dest_busy = {7'h0, st}, core_src_busy = {7'h0, st};
    int bad_count = 0, num_checks = 0;
    slc_row_t rows [13] = '{
        '{8'h10, 32'hFFFFFFFF, 32'h00000003, 2'h0},
        '{8'h11, 32'hFFFFFFFE, 32'h00000002, 2'h0},
        '{8'h1F, 32'hFFFFFFFF, 32'h00000013, 2'h0},
        '{8'h20, 32'hFFFFFFFF, 32'h025A0F37, 2'h0},
        '{8'h28, 32'h00000A20, 32'h00000A20, 2'h0},
        '{8'h29, 32'hFFFFFFFF, 32'h00000000, 2'h2},
        '{8'h40, 32'hFFFFFFFF, 32'h01030037, 2'h0},
        '{8'h47, 32'h00000F20, 32'h00000020, 2'h0},
        '{8'h48, 32'h00000001, 32'h00000000, 2'h2},
        '{8'h81, 32'hFFFFFFFF, 32'hC63FFFFF, 2'h0},
        '{8'h88, 32'h40000000, 32'h40000000, 2'h0},
        '{8'hA0, 32'hFFFFFFFF, 32'h8000011F, 2'h0},
        '{8'hA7, 32'h80000005, 32'h80000005, 2'h0}};
    slc_regs i_slc_regs (.*);
    slc_link_peer i_slc_link_peer (.*);
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic tmo;
        bad_count++;
        results();
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [3:0] sb,
                      output logic [1:0] rsp);
        logic a, w, b;
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= d;
        s_axi_wstrb <= sb;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        b = 1'h0;
        for (n = 0; n < 50 && !b; n++) begin
            @(negedge clk_sys);
            a = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge clk_sys);
            if (a) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            s_axi_bready <= s_axi_bvalid && !b;
        end
        if (!b) tmo();
    endtask
    task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] rsp);
        logic a, r;
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'h1;
        r = 1'h0;
        for (n = 0; n < 50 && !r; n++) begin
            @(negedge clk_sys);
            a = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk_sys);
            if (a) s_axi_arvalid <= 1'h0;
            s_axi_rready <= s_axi_rvalid && !r;
        end
        if (!r) tmo();
    endtask
    task automatic rchk(input string nm, input logic [7:0] i, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] s;
        rd(i, d, s);
        chk(nm, e, d);
    endtask
    task automatic acc(input slc_row_t r);
        logic [31:0] d;
        logic [1:0] s;
        wr(r.i, r.w, 4'hF, s);
        chk($sformatf("wresp %h", r.i), r.s, s);
        rd(r.i, d, s);
        chk($sformatf("rdata %h", r.i), r.r, d);
        chk($sformatf("rresp %h", r.i), r.s, s);
    endtask
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        int k;
        int t;
        int g [3];
        logic [1:0] s;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        rchk("status_rst", 8'h20, 32'h0);
        rchk("setup_rst", 8'h80, 32'h0);
        st <= 1'h1;
        foreach (rows[k]) acc(rows[k]);
        chk("enable", 64'h2, 64'(link_enable));
        chk("five_wire", 64'h102, 64'(link_five_wire));
        chk("direction", 64'hA0000000F, 64'(link_direction));
        chk("ext_net", 64'h20003, 64'(ext_network));
        chk("core_net", 64'h8003, 64'(core_network));
        chk("fwd", 64'h8101, 64'({fwd_enable, fwd_core}));
        chk("chanend", 64'h280000001F, 64'(fwd_chanend));
        for (k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            halt_by_core_zero <= k[0];
            halt_by_core_one <= !k[0];
            global_halt_event <= 1'h1;
            @(posedge clk_sys);
            global_halt_event <= 1'h0;
            rchk("debug", 8'h1F, k ? 32'h11 : 32'h12);
        end
        @(posedge clk_sys);
        inject_error <= 1'h1;
        @(posedge clk_sys);
        inject_error <= 1'h0;
        rchk("rx_error", 8'h80, 32'h08000000);
        wr(8'h80, 32'h00800000, 4'h4, s);
        rchk("rx_reset", 8'h80, 32'h0);
        wr(8'h80, 32'h81001003, 4'hF, s);
        rchk("credit", 8'h80, 32'h86001003);
        k = 0;
        for (t = 0; t < 300 && k < 3; t++) begin
            @(negedge clk_sys);
            if (tx_symbol_go[0]) begin
                g[k] = t;
                k++;
            end
        end
        if (k < 3) tmo();
        chk("gap_sum", 64'h9, 64'(g[2] - g[0]));
        chk("gap_prod", 64'h14, 64'((g[1] - g[0]) * (g[2] - g[1])));
        wr(8'hC0, 32'h0, 4'hF, s);
        wr(8'hC1, 32'h0, 4'hF, s);
        wr(8'hC1, 32'h76543210, 4'hF, s);
        for (k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            route_dest_id <= k ? 16'h0088 : 16'h0020;
            @(negedge clk_sys);
            chk("route_dir", k ? 64'h7 : 64'h5, 64'(route_dir));
        end
        results();
    end
endmodule // switch_link_config_regs_tb_top
`default_nettype wire
